// *** hdl/aph_pkg.sv ***
// Shared constants and types for the audio port configuration block
package aph_pkg;
    // APB byte offsets
    localparam logic [7:0] ADDR_MSG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_SEL = 8'h0C;
    localparam logic [7:0] ADDR_CW = 8'h10;
    localparam logic [7:0] ADDR_IN = 8'h14;
    localparam logic [7:0] ADDR_OUT = 8'h18;
    // CTRL bit positions
    localparam int CTRL_RESTART = 0;
    localparam int CTRL_CLR_ERR = 1;
    localparam int CTRL_IN_I2S = 2;
    // Upper sixteen bits of a command word
    localparam logic [15:0] CMD_WR = 16'h8000;
    localparam logic [15:0] CMD_OR = 16'h8001;
    localparam logic [15:0] CMD_AND = 16'h8002;
    // Control words held on chip, their message addresses and reset values
    localparam int N_CW = 8;
    localparam logic [7:0] CW_ADDR [N_CW] = '{8'h10, 8'h14, 8'h17, 8'h1A,
                                             8'h7C, 8'h7D, 8'h7E, 8'h7F};
    localparam logic [23:0] CW_RST [N_CW] = '{24'h000000, 24'h000000,
        24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
        24'h43A100};
    localparam logic [2:0] IDX_FIFO = 3'h1;
    localparam logic [2:0] IDX_OUT = 3'h7;
    // Fields of the output control word
    localparam int BIT_CLK_SLAVE = 22;
    localparam int BIT_MCLK_IN = 13;
    localparam int FMT_LSB = 15;
    localparam logic [2:0] FMT_I2S = 3'h7;
    // Input FIFO settings
    localparam logic [23:0] FIFO_COMP_VAL = 24'h280D00;
    localparam logic [23:0] FIFO_PCM_VAL = 24'h820300;
    // Last bit index of a captured word, and captured word sizes
    localparam logic [4:0] PCM_LAST = 5'h17;
    localparam logic [4:0] COMP_LAST = 5'h0F;
    localparam logic [4:0] PCM_COUNT = 5'h18;
    localparam logic [4:0] COMP_COUNT = 5'h10;
    localparam logic [4:0] SLOT_MAX = 5'h1F;
    localparam logic [15:0] COMP_SYNC_DEF = 16'hF872;

    typedef enum logic [1:0] {
        CLK_ALL_IN,
        CLK_BIT_FRAME_OUT,
        CLK_ALL_OUT
    } aph_clk_mode_t;

    typedef enum logic {
        MSG_CMD,
        MSG_MASK
    } aph_msg_state_t;
endpackage : aph_pkg

// *** hdl/aph_sync3.sv ***
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module aph_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (s2_reg == s3_reg) begin
            q <= s3_reg;
        end
    end
endmodule : aph_sync3
`default_nettype wire

// *** hdl/aph_link.sv ***
// Bit-clock domain: frame tracking, input word capture, output serialiser
`timescale 1ns/100ps
`default_nettype none
module aph_link (
    input wire logic bclk,
    input wire logic rst_n,
    input wire logic master,
    input wire logic pcm,
    input wire logic in_en,
    input wire logic in_i2s,
    input wire logic out_i2s,
    input wire logic clr_tgl,
    input wire logic out_tgl,
    input wire logic frame_clk_i,
    input wire logic audio_in_line,
    input wire logic [23:0] out_word,
    output logic frame_clk_o,
    output logic in_tgl_o,
    output logic [23:0] in_word_o,
    output logic out_ack_o,
    output logic audio_out_line_zero
);
    import aph_pkg::*;
    logic fr, fr_d_reg, clr_d_reg, out_d_reg, hold_reg, pcm_d_reg;
    logic edge_det, clr_evt, stop, cap, load;
    logic [4:0] pos_reg, mcnt_reg, cur, roff, rel, last, cap_cnt_reg;
    logic [22:0] sh_reg;
    logic [23:0] out_buf_reg, osh_reg;

    assign fr = master ? frame_clk_o : frame_clk_i;
    assign edge_det = fr != fr_d_reg;
    // Saturate so an over-long sub-frame never restarts a capture
    assign cur = edge_det ? 5'h00 :
                 (pos_reg == SLOT_MAX) ? SLOT_MAX : pos_reg + 5'h01;
    assign roff = in_i2s ? 5'h01 : 5'h00;
    assign rel = cur - roff;
    assign last = pcm ? PCM_LAST : COMP_LAST;
    assign clr_evt = clr_tgl != clr_d_reg;
    // Capture only whole sub-frames: enabling the port or changing the word
    // size mid-frame would otherwise hand over a partial word
    assign stop = clr_evt || !in_en || pcm != pcm_d_reg;
    assign cap = !stop && (!hold_reg || edge_det) && cur >= roff &&
                 rel <= last;
    assign load = cur == (out_i2s ? 5'h01 : 5'h00);

    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            fr_d_reg <= 1'b0;
            pos_reg <= SLOT_MAX;
            mcnt_reg <= 5'h00;
            frame_clk_o <= 1'b0;
        end else begin
            fr_d_reg <= fr;
            pos_reg <= cur;
            mcnt_reg <= mcnt_reg + 5'h01;
            if (mcnt_reg == SLOT_MAX) begin
                frame_clk_o <= ~frame_clk_o;
            end
        end
    end

    // A clear drops the rest of the current sub-frame
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            clr_d_reg <= 1'b0;
            pcm_d_reg <= 1'b0;
            hold_reg <= 1'b1;
        end else begin
            clr_d_reg <= clr_tgl;
            pcm_d_reg <= pcm;
            if (stop) begin
                hold_reg <= 1'b1;
            end else if (edge_det) begin
                hold_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg <= '0;
            in_word_o <= '0;
            in_tgl_o <= 1'b0;
            cap_cnt_reg <= 5'h00;
        end else begin
            if (edge_det) begin
                cap_cnt_reg <= cap ? 5'h01 : 5'h00;
            end else if (cap) begin
                cap_cnt_reg <= cap_cnt_reg + 5'h01;
            end
            if (cap) begin
                sh_reg <= {sh_reg[21:0], audio_in_line};
                if (rel == last) begin
                    if (pcm) begin
                        in_word_o <= {sh_reg, audio_in_line};
                    end else begin
                        in_word_o <= {8'h00, sh_reg[14:0], audio_in_line};
                    end
                    in_tgl_o <= ~in_tgl_o;
                end
            end
        end
    end

    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            out_d_reg <= 1'b0;
            out_ack_o <= 1'b0;
            out_buf_reg <= '0;
        end else begin
            out_d_reg <= out_tgl;
            if (out_tgl != out_d_reg) begin
                out_buf_reg <= out_word;
                out_ack_o <= ~out_ack_o;
            end
        end
    end

    // Every slot carries a full 24-bit word, zeros after it
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            osh_reg <= '0;
            audio_out_line_zero <= 1'b0;
        end else if (load) begin
            audio_out_line_zero <= out_buf_reg[23];
            osh_reg <= {out_buf_reg[22:0], 1'b0};
        end else begin
            audio_out_line_zero <= osh_reg[23];
            osh_reg <= {osh_reg[22:0], 1'b0};
        end
    end

    default clocking cb @(posedge bclk); endclocking
    default disable iff (!rst_n);

    chk_pcm_width: assert property ($changed(in_tgl_o) && $past(pcm)
        |-> cap_cnt_reg == PCM_COUNT) else $error("PCM word not 24 bits");
    chk_comp_width: assert property ($changed(in_tgl_o) && !$past(pcm)
        |-> cap_cnt_reg == COMP_COUNT) else $error("compressed word not 16");
    chk_out_word: assert property (load ##1 !load [*8]
        |-> ##16 audio_out_line_zero == $past(out_buf_reg[0], 24))
        else $error("output word not 24 bits");
    cov_pcm_word: cover property ($changed(in_tgl_o) && pcm);
endmodule : aph_link
`default_nettype wire

// *** hdl/aph_audio_port_cfg.sv ***
// Audio port configuration block: APB slave, message engine, link crossings
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - PCM input always captured as 24 bits
// - Compressed input captured as 16-bit words
// - FIFO setting 1: compressed FIFO, no default
// - FIFO setting 2: PCM FIFO, two-word message
// - Any restart or reset clears input FIFO
// - Compressed input resynchronises on sync words
// - Clock mode: all in, bit/frame out, all out
// - Output format codes; multichannel uses line zero
// - Every PCM output sample is 24 bits
module aph_audio_port_cfg #(
    parameter logic [15:0] COMP_SYNC = aph_pkg::COMP_SYNC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_bclk,
    input wire logic frame_clk_i,
    output logic frame_clk_o,
    output logic frame_clk_oe,
    output logic bit_clk_o,
    output logic bit_clk_oe,
    output logic mclk_o,
    output logic mclk_oe,
    input wire logic audio_in_line,
    output logic audio_out_line_zero
);
    import aph_pkg::*;

    logic apb_setup, apb_done, addr_ok;
    logic wr_msg, apply, restart, clr_err, pop, wr_out;
    logic is_and, is_or, is_wr, any_hit;
    logic [N_CW-1:0] hit;
    logic [23:0] mask, cw_out;
    logic [23:0] cw_reg [N_CW];
    logic [23:0] cmd_reg, in_word_reg, out_word_reg;
    logic [23:0] link_in_word;
    logic [2:0] sel_reg, fmt;
    logic [1:0] div_reg;
    logic [1:0] from_link, from_link_s;
    logic [6:0] to_link, to_link_s;
    logic [31:0] rd_mux;
    aph_msg_state_t msg_state_reg;
    aph_clk_mode_t clk_mode;
    logic cmd_err_reg, ctrl_in_i2s_reg, in_valid_reg, in_sync_reg;
    logic overrun_reg, out_busy_reg, clr_tgl_reg, out_req_tgl_reg;
    logic in_prev_reg, ack_prev_reg, in_evt, ack_evt, take_word;
    logic in_pcm, in_en, out_i2s, link_frame_o, link_in_tgl, link_ack;

    // APB decode; only a write to OUT_DATA while busy stretches the access
    assign apb_setup = psel && !penable;
    assign pready = !(psel && pwrite && paddr == ADDR_OUT && out_busy_reg);
    assign apb_done = psel && penable && pready;
    always_comb begin
        case (paddr)
            ADDR_MSG, ADDR_STATUS, ADDR_CTRL, ADDR_SEL,
            ADDR_CW, ADDR_IN, ADDR_OUT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    assign wr_msg = apb_done && pwrite && paddr == ADDR_MSG;
    assign restart = apb_done && pwrite && paddr == ADDR_CTRL &&
                     pwdata[CTRL_RESTART];
    assign clr_err = apb_done && pwrite && paddr == ADDR_CTRL &&
                     pwdata[CTRL_CLR_ERR];
    assign pop = apb_done && !pwrite && paddr == ADDR_IN;
    assign wr_out = apb_done && pwrite && paddr == ADDR_OUT;

    // Message engine: a command word, then its mask word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_state_reg <= MSG_CMD;
            cmd_reg <= '0;
        end else if (restart) begin
            msg_state_reg <= MSG_CMD;
        end else if (wr_msg) begin
            unique case (msg_state_reg)
                MSG_CMD: begin
                    cmd_reg <= pwdata[23:0];
                    msg_state_reg <= MSG_MASK;
                end
                MSG_MASK: msg_state_reg <= MSG_CMD;
            endcase
        end
    end

    assign apply = wr_msg && msg_state_reg == MSG_MASK;
    assign mask = pwdata[23:0];
    assign is_and = cmd_reg[23:8] == CMD_AND;
    assign is_or = cmd_reg[23:8] == CMD_OR;
    assign is_wr = cmd_reg[23:8] == CMD_WR;
    assign any_hit = |hit;

    for (genvar i = 0; i < N_CW; i++) begin : g_cw
        assign hit[i] = cmd_reg[7:0] == CW_ADDR[i];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cw_reg[i] <= CW_RST[i];
            end else if (apply && hit[i]) begin
                if (is_and) begin
                    cw_reg[i] <= cw_reg[i] & mask;
                end else if (is_or) begin
                    cw_reg[i] <= cw_reg[i] | mask;
                end else if (is_wr) begin
                    cw_reg[i] <= mask;
                end
            end
        end
    end

    // Unknown command or address; a new error beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_err_reg <= 1'b0;
        end else if (apply && (!(is_and || is_or || is_wr) || !any_hit)) begin
            cmd_err_reg <= 1'b1;
        end else if (clr_err) begin
            cmd_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_in_i2s_reg <= 1'b0;
            sel_reg <= 3'h0;
        end else if (apb_done && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_in_i2s_reg <= pwdata[CTRL_IN_I2S];
            end
            if (paddr == ADDR_SEL) begin
                sel_reg <= pwdata[2:0];
            end
        end
    end

    // Decoded configuration
    assign cw_out = cw_reg[IDX_OUT];
    always_comb begin
        if (cw_out[BIT_CLK_SLAVE]) begin
            clk_mode = CLK_ALL_IN;
        end else if (cw_out[BIT_MCLK_IN]) begin
            clk_mode = CLK_BIT_FRAME_OUT;
        end else begin
            clk_mode = CLK_ALL_OUT;
        end
    end
    assign fmt = cw_out[FMT_LSB +: 3];
    assign out_i2s = fmt == FMT_I2S;
    // No FIFO setting is held after reset, so capture stays off until set
    assign in_pcm = cw_reg[IDX_FIFO] == FIFO_PCM_VAL;
    assign in_en = in_pcm || cw_reg[IDX_FIFO] == FIFO_COMP_VAL;

    // Clock pins; the divider gives the bit clock driven in both master modes and the master clock driven in all-out mode only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 2'h0;
            bit_clk_oe <= 1'b0;
            frame_clk_oe <= 1'b0;
            mclk_oe <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            bit_clk_oe <= clk_mode != CLK_ALL_IN;
            frame_clk_oe <= clk_mode != CLK_ALL_IN;
            mclk_oe <= clk_mode == CLK_ALL_OUT;
        end
    end
    assign mclk_o = div_reg[0];
    assign bit_clk_o = div_reg[1];
    assign frame_clk_o = link_frame_o;

    // Crossings: levels are quasi-static, events travel as toggles
    assign to_link = {clr_tgl_reg, out_req_tgl_reg, clk_mode != CLK_ALL_IN,
                      in_pcm, in_en, ctrl_in_i2s_reg, out_i2s};
    assign from_link = {link_in_tgl, link_ack};

    aph_sync3 #(.W(7)) u_to_link (
        .clk(link_bclk),
        .rst_n(presetn),
        .d(to_link),
        .q(to_link_s)
    );

    aph_sync3 #(.W(2)) u_to_pclk (
        .clk(pclk),
        .rst_n(presetn),
        .d(from_link),
        .q(from_link_s)
    );

    aph_link u_link (
        .bclk(link_bclk),
        .rst_n(presetn),
        .master(to_link_s[4]),
        .pcm(to_link_s[3]),
        .in_en(to_link_s[2]),
        .in_i2s(to_link_s[1]),
        .out_i2s(to_link_s[0]),
        .clr_tgl(to_link_s[6]),
        .out_tgl(to_link_s[5]),
        .frame_clk_i(frame_clk_i),
        .audio_in_line(audio_in_line),
        .out_word(out_word_reg),
        .frame_clk_o(link_frame_o),
        .in_tgl_o(link_in_tgl),
        .in_word_o(link_in_word),
        .out_ack_o(link_ack),
        .audio_out_line_zero(audio_out_line_zero)
    );

    assign in_evt = from_link_s[1] != in_prev_reg;
    assign ack_evt = from_link_s[0] != ack_prev_reg;
    // Word bus from the link stays stable for a whole sub-frame after a toggle
    assign take_word = in_evt && (in_pcm || in_sync_reg ||
                                  link_in_word[15:0] == COMP_SYNC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev_reg <= 1'b0;
            ack_prev_reg <= 1'b0;
            clr_tgl_reg <= 1'b0;
        end else begin
            in_prev_reg <= from_link_s[1];
            ack_prev_reg <= from_link_s[0];
            if (restart) begin
                clr_tgl_reg <= ~clr_tgl_reg;
            end
        end
    end

    // Input holding word; a restart discards it, even a word arriving then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid_reg <= 1'b0;
            in_sync_reg <= 1'b0;
            in_word_reg <= '0;
        end else if (restart) begin
            in_valid_reg <= 1'b0;
            in_sync_reg <= 1'b0;
        end else begin
            if (in_evt && !in_pcm && link_in_word[15:0] == COMP_SYNC) begin
                in_sync_reg <= 1'b1;
            end
            if (take_word) begin
                in_word_reg <= link_in_word;
                in_valid_reg <= 1'b1;
            end else if (pop) begin
                in_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_reg <= 1'b0;
        end else if (take_word && in_valid_reg && !pop) begin
            overrun_reg <= 1'b1;
        end else if (clr_err) begin
            overrun_reg <= 1'b0;
        end
    end

    // Output sample handshake to the link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_word_reg <= '0;
            out_req_tgl_reg <= 1'b0;
            out_busy_reg <= 1'b0;
        end else if (wr_out) begin
            out_word_reg <= pwdata[23:0];
            out_req_tgl_reg <= ~out_req_tgl_reg;
            out_busy_reg <= 1'b1;
        end else if (ack_evt) begin
            out_busy_reg <= 1'b0;
        end
    end

    always_comb begin
        case (paddr)
            ADDR_STATUS: rd_mux = {16'h0000, 5'h00, fmt, clk_mode,
                                   out_busy_reg, overrun_reg, in_sync_reg,
                                   in_valid_reg, cmd_err_reg,
                                   msg_state_reg == MSG_MASK};
            ADDR_CTRL: rd_mux = {29'h00000000, ctrl_in_i2s_reg, 2'h0};
            ADDR_SEL: rd_mux = {29'h00000000, sel_reg};
            ADDR_CW: rd_mux = {8'h00, cw_reg[sel_reg]};
            ADDR_IN: rd_mux = {8'h00, in_word_reg};
            ADDR_OUT: rd_mux = {8'h00, out_word_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            prdata <= rd_mux;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_and_apply: assert property (apply && is_and && hit[IDX_OUT]
        |=> cw_out == ($past(cw_out) & $past(mask)))
        else $error("AND message not applied");
    chk_or_apply: assert property (apply && is_or && hit[IDX_OUT]
        |=> cw_out == ($past(cw_out) | $past(mask)))
        else $error("OR message not applied");
    chk_restart_clear: assert property (restart
        |=> !in_valid_reg && !in_sync_reg ##1 !in_valid_reg)
        else $error("restart left input data");
    chk_comp_gate: assert property (in_evt && !in_pcm && !in_sync_reg
        && link_in_word[15:0] != COMP_SYNC |=> $stable(in_word_reg))
        else $error("compressed word taken before sync");
    chk_slave_pins: assert property (cw_out[BIT_CLK_SLAVE]
        |=> !bit_clk_oe && !frame_clk_oe && !mclk_oe)
        else $error("clock driven in slave mode");
    chk_master_pins: assert property (!cw_out[BIT_CLK_SLAVE]
        && !cw_out[BIT_MCLK_IN] |=> mclk_oe && bit_clk_oe)
        else $error("clocks not driven in full master mode");
    chk_fifo_pcm: assert property (apply && is_wr && hit[IDX_FIFO]
        && mask == FIFO_PCM_VAL |=> in_pcm && in_en)
        else $error("PCM FIFO setting not taken");
    chk_fifo_comp: assert property (apply && is_wr && hit[IDX_FIFO]
        && mask == FIFO_COMP_VAL |=> !in_pcm && in_en)
        else $error("compressed FIFO setting not taken");
    chk_fmt_clear: assert property (apply && is_and && hit[IDX_OUT]
        && mask[FMT_LSB +: 3] == 3'h0 |=> fmt == 3'h0 && !out_i2s)
        else $error("format field not cleared");
    chk_out_wait: assert property (psel && penable && pwrite
        && paddr == ADDR_OUT && out_busy_reg |-> !pready)
        else $error("output write accepted while busy");

    cov_and_msg: cover property (apply && is_and && any_hit);
    cov_comp_sync: cover property (take_word && !in_pcm && !in_sync_reg);
    cov_out_stall: cover property (psel && penable && !pready ##1 pready);
endmodule : aph_audio_port_cfg
`default_nettype wire

// *** sim/aph_src_model.sv ***
// Audio source model: frame clock and left-justified PCM words
`timescale 1ns/100ps
`default_nettype none
module aph_src_model (
    input wire logic bclk,
    input wire logic rst_n,
    input wire logic [23:0] word,
    output logic frame,
    output logic data
);
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    assign cnt_next = cnt_reg + 5'h01;
    // 32 bit clocks per sub-frame, the first 24 carry the sample
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 5'h00;
            frame <= 1'b0;
            data <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            // 64Fs bit clock: fine for the stereo formats the bench selects
            if (cnt_reg == 5'h1F) frame <= ~frame;
            // Unused slot bits toggle so a stale value never looks valid
            if (cnt_next < 5'h18) data <= word[5'h17 - cnt_next];
            else data <= ~data;
        end
    end
endmodule : aph_src_model
`default_nettype wire

// *** sim/aph_audio_port_cfg_tb.sv ***
// Testbench for the audio port configuration block
`timescale 1ns/100ps
`default_nettype none
module aph_audio_port_cfg_tb;
    import aph_pkg::*;
    logic pclk = 1'b0;
    logic link_bclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, frame, sdata, bit_clk_oe, mclk_oe;
    logic frame_oe, sout;
    int failures = 0;
    int compares = 0;
    always #5 pclk = ~pclk;
    // Offset start keeps the link clock out of phase with pclk
    initial begin
        #1.3;
        forever #3 link_bclk = ~link_bclk;
    end
    aph_audio_port_cfg #(.COMP_SYNC(16'hA5C3)) i_aph_audio_port_cfg (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_bclk(link_bclk),
        .frame_clk_i(frame), .frame_clk_o(), .frame_clk_oe(frame_oe),
        .bit_clk_o(), .bit_clk_oe(bit_clk_oe), .mclk_o(),
        .mclk_oe(mclk_oe), .audio_in_line(sdata),
        .audio_out_line_zero(sout));
    aph_src_model i_aph_src_model (.bclk(link_bclk), .rst_n(presetn),
        .word(24'hA5C3E1), .frame(frame), .data(sdata));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic msg(input logic [23:0] c, input logic [23:0] m);
        apb(1'b1, ADDR_MSG, {8'h00, c});
        apb(1'b1, ADDR_MSG, {8'h00, m});
    endtask : msg
    task automatic cw(input logic [2:0] i);
        apb(1'b1, ADDR_SEL, {29'h0, i});
        apb(1'b0, ADDR_CW, 32'h0);
    endtask : cw
    task automatic mode(input logic [1:0] e);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, rd[7:6]}, {30'h0, e});
        chk({29'h0, bit_clk_oe, frame_oe, mclk_oe},
            {29'h0, e != 2'h0, e != 2'h0, e == 2'h2});
    endtask : mode
    task automatic wait_valid;
        for (int n = 0; n < 60; n++) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (rd[2] === 1'b1) break;
        end
    endtask : wait_valid
    task automatic t_clock_mode;
        cw(IDX_OUT);
        chk(rd, 32'h0043A100);
        mode(2'h0);
        msg(24'h80027F, 24'hBFFFFF);
        mode(2'h1);
        cw(IDX_OUT);
        chk(rd, 32'h0003A100);
        msg(24'h80027F, 24'hBFDFFF);
        mode(2'h2);
        msg(24'h80017F, 24'h400000);
        mode(2'h0);
        cw(IDX_OUT);
        chk(rd, 32'h00438100);
    endtask : t_clock_mode
    task automatic t_format;
        msg(24'h80027F, 24'hFC7FFF);
        msg(24'h80017F, 24'h018000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({29'h0, rd[10:8]}, 32'h3);
        msg(24'h80017F, 24'h038000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({29'h0, rd[10:8]}, 32'h7);
        msg(24'h800299, 24'h000000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h0);
    endtask : t_format
    task automatic t_pcm;
        msg(24'h800014, 24'h820300);
        cw(IDX_FIFO);
        chk(rd, 32'h00820300);
        wait_valid();
        apb(1'b0, ADDR_IN, 32'h0);
        chk(rd, 32'h00A5C3E1);
        wait_valid();
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h0);
    endtask : t_pcm
    task automatic t_comp;
        msg(24'h800014, 24'h280D00);
        cw(IDX_FIFO);
        chk(rd, 32'h00280D00);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_valid();
        apb(1'b0, ADDR_IN, 32'h0);
        chk(rd, 32'h0000A5C3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[3]}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_comp
    task automatic t_out;
        logic [23:0] w;
        w = 24'h000000;
        apb(1'b1, ADDR_OUT, 32'h005A3C96);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({31'h0, rd[5]}, 32'h1);
        apb(1'b1, ADDR_OUT, 32'h005A3C96);
        apb(1'b0, ADDR_OUT, 32'h0);
        chk(rd, 32'h005A3C96);
        // I2S slot: the MSB leaves two bit clocks after the frame edge
        @(frame);
        repeat (2) @(posedge link_bclk);
        for (int k = 0; k < 24; k++) begin
            @(negedge link_bclk);
            w = {w[22:0], sout};
        end
        chk({8'h00, w}, 32'h005A3C96);
    endtask : t_out
    task automatic finish_test;
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_clock_mode();
        t_format();
        t_pcm();
        t_comp();
        t_out();
        finish_test();
    end
    initial begin
        #100000;
        failures++;
        finish_test();
    end
endmodule : aph_audio_port_cfg_tb
`default_nettype wire
